// ### inc/urbs_defines.svh
// urbs_defines.svh: offsets, field positions, reset values and timing counts
// for the serial port modem-ready and line-break mirror block.
// assumes: included by bare name; holds definitions only.
`ifndef URBS_DEFINES_SVH
`define URBS_DEFINES_SVH

// byte addresses on the register bus
`define URBS_ADR_FIFO_CTRL      32'h5000_1008
`define URBS_ADR_LINE_CTRL      32'h5000_100C
`define URBS_ADR_MODEM_CTRL     32'h5000_1010
`define URBS_ADR_MIRROR_RDY     32'h5000_108C
`define URBS_ADR_MIRROR_BRK     32'h5000_1090

// reset values
`define URBS_RST_MODEM_CTRL     8'h00
`define URBS_RST_LINE_CTRL      8'h00
`define URBS_RST_FIFO_CTRL      8'h00

// writable bit masks
`define URBS_MASK_MODEM_CTRL    8'h7F
`define URBS_MASK_LINE_CTRL     8'hFF
`define URBS_MASK_FIFO_CTRL     8'hC9

// modem control fields
`define URBS_MCR_RDY            1
`define URBS_MCR_LOOP           4
`define URBS_MCR_AUTO           5
`define URBS_MCR_IR             6

// line control and fifo control fields
`define URBS_LCR_BRK            6
`define URBS_FCR_EN             0
`define URBS_FCR_TRIG_HI        7
`define URBS_FCR_TRIG_LO        6

// mirror register bit
`define URBS_MIRROR_BIT         0

// receive fifo depth and trigger fill levels
`define URBS_FIFO_DEPTH         5'd16
`define URBS_TRIG_ONE           5'd1
`define URBS_TRIG_QUARTER       5'd4
`define URBS_TRIG_HALF          5'd8
`define URBS_TRIG_NEAR_FULL     5'd14

// infrared break pulse train: last count of the 16-cycle period, and low width in clock cycles
`define URBS_IR_PERIOD_CYC      4'd15
`define URBS_IR_LOW_CYC         4'd3

`endif

// ### inc/urbs_pkg.sv
// urbs_pkg: types of the modem-ready and line-break mirror block.
// assumes: constants come from urbs_defines.svh.
package urbs_pkg;

	typedef enum logic [1:0] {
		URBS_BUS_IDLE = 2'b01,
		URBS_BUS_ACK  = 2'b10
	} urbs_bus_t;

	typedef struct packed {
		urbs_bus_t   bus;
		logic [31:0] dat;
		logic        ack;
		logic [7:0]  modem_control_reg;
		logic [7:0]  line_control_reg;
		logic [7:0]  fifo_control_reg;
		logic        rts_n;
		logic        ser_out;
		logic        ir_out_n;
		logic        lb_rdy;
		logic        lb_rx;
	} urbs_state_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       pulse_n;
	} urbs_ir_state_t;

endpackage : urbs_pkg

// ### design/urbs_ir_pulse.sv
// urbs_ir_pulse: free pulse train for the infrared output during break.
// assumes: en is a registered level; output low for low_cyc of each period.
`timescale 1ns/1ps
`include "urbs_defines.svh"

module urbs_ir_pulse (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic en,
	output logic      pulse_n
);
	import urbs_pkg::*;

	urbs_ir_state_t q;
	urbs_ir_state_t d;

	always_comb begin
		d = q;
		if (!en) begin
			d.cnt     = 4'h0;
			d.pulse_n = 1'b1;
		end else begin
			// counter restarts each period so the pulse repeats for the whole break
			if (q.cnt >= `URBS_IR_PERIOD_CYC)
				d.cnt = 4'h0;
			else
				d.cnt = q.cnt + 4'h1;
			d.pulse_n = (q.cnt >= `URBS_IR_LOW_CYC);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q.cnt     <= 4'h0;
			q.pulse_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign pulse_n = q.pulse_n;

endmodule : urbs_ir_pulse

// ### design/urbs_ctrl.sv
// urbs_ctrl: modem-ready and line-break control with mirror registers,
// reached over a classic wishbone slave with 32-bit data.
// assumes: framing logic supplies the serial and infrared bit streams and the
// receive fifo fill; all inputs are synchronous to clk.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "urbs_defines.svh"

module urbs_ctrl #(
	parameter bit AUTO_FLOW_OPTION = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [4:0]  rx_fifo_level,
	input  wire logic        tx_serial_in,
	input  wire logic        ir_serial_in_n,
	output logic             modem_ready_n,
	output logic             ser_out,
	output logic             ir_out_n,
	output logic             loop_modem_ready,
	output logic             loop_rx_in
);
	import urbs_pkg::*;

	urbs_state_t q;
	urbs_state_t d;
	logic        ir_pulse_n;
	logic        ir_burst;

	// read mux; single storage per bit keeps both views identical
	function automatic logic [31:0] rd_word(
		input logic [31:0] adr,
		input logic [7:0]  modem_control_reg,
		input logic [7:0]  line_control_reg,
		input logic [7:0]  fifo_control_reg
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (adr)
			`URBS_ADR_MODEM_CTRL: begin
				w[7:0] = modem_control_reg;
			end
			`URBS_ADR_LINE_CTRL: begin
				w[7:0] = line_control_reg;
			end
			`URBS_ADR_FIFO_CTRL: begin
				w[7:0] = fifo_control_reg;
			end
			`URBS_ADR_MIRROR_RDY: begin
				w[`URBS_MIRROR_BIT] = modem_control_reg[`URBS_MCR_RDY];
			end
			`URBS_ADR_MIRROR_BRK: begin
				w[`URBS_MIRROR_BIT] = line_control_reg[`URBS_LCR_BRK];
			end
			default: begin
				// unmapped reads answer zero
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction : rd_word

	// receive trigger fill level from the two-bit field
	function automatic logic [4:0] trig_level(
		input logic [1:0] sel
	);
		logic [4:0] lvl;
		lvl = `URBS_TRIG_ONE;
		case (sel)
			2'b00: begin
				lvl = `URBS_TRIG_ONE;
			end
			2'b01: begin
				lvl = `URBS_TRIG_QUARTER;
			end
			2'b10: begin
				lvl = `URBS_TRIG_HALF;
			end
			2'b11: begin
				lvl = `URBS_TRIG_NEAR_FULL;
			end
			default: begin
				lvl = `URBS_TRIG_ONE;
			end
		endcase
		return lvl;
	endfunction : trig_level

	logic       req;
	logic       wr_lane0;
	logic       loop_on;
	logic       brk_on;
	logic       auto_on;
	logic       rx_over;
	logic [4:0] trig;

	always_comb begin
		d        = q;
		req      = wb_cyc_i & wb_stb_i;
		wr_lane0 = req & wb_we_i & wb_sel_i[0];
		d.ack    = 1'b0;

		case (q.bus)
			URBS_BUS_IDLE: begin
				if (req) begin
					d.bus = URBS_BUS_ACK;
					d.ack = 1'b1;
					d.dat = rd_word(wb_adr_i, q.modem_control_reg, q.line_control_reg, q.fifo_control_reg);
					if (wr_lane0) begin
						case (wb_adr_i)
							`URBS_ADR_MODEM_CTRL: begin
								d.modem_control_reg = wb_dat_i[7:0] & `URBS_MASK_MODEM_CTRL;
							end
							`URBS_ADR_LINE_CTRL: begin
								d.line_control_reg = wb_dat_i[7:0] & `URBS_MASK_LINE_CTRL;
							end
							`URBS_ADR_FIFO_CTRL: begin
								d.fifo_control_reg = wb_dat_i[7:0] & `URBS_MASK_FIFO_CTRL;
							end
							`URBS_ADR_MIRROR_RDY: begin
								// upper bits dropped on purpose
								d.modem_control_reg[`URBS_MCR_RDY] = wb_dat_i[`URBS_MIRROR_BIT];
							end
							`URBS_ADR_MIRROR_BRK: begin
								d.line_control_reg[`URBS_LCR_BRK] = wb_dat_i[`URBS_MIRROR_BIT];
							end
							default: begin
								// unmapped writes are acknowledged and dropped
								d.modem_control_reg = q.modem_control_reg;
							end
						endcase
					end
				end
			end
			URBS_BUS_ACK: begin
				// one idle cycle after each ack so a held strobe is not taken twice
				d.bus = URBS_BUS_IDLE;
			end
			default: begin
				d.bus = URBS_BUS_IDLE;
			end
		endcase

		loop_on = q.modem_control_reg[`URBS_MCR_LOOP];
		brk_on  = q.line_control_reg[`URBS_LCR_BRK];
		auto_on = AUTO_FLOW_OPTION & q.modem_control_reg[`URBS_MCR_AUTO] & q.fifo_control_reg[`URBS_FCR_EN];
		trig    = trig_level(q.fifo_control_reg[`URBS_FCR_TRIG_HI:`URBS_FCR_TRIG_LO]);
		rx_over = (rx_fifo_level >= trig);

		// ready output
		if (loop_on)
			d.rts_n = 1'b1;
		else if (auto_on && rx_over)
			d.rts_n = 1'b1;
		else
			d.rts_n = ~q.modem_control_reg[`URBS_MCR_RDY];
		d.lb_rdy = q.modem_control_reg[`URBS_MCR_RDY];

		// serial line; loopback keeps the pin idle high
		if (loop_on)
			d.ser_out = 1'b1;
		else if (brk_on)
			d.ser_out = 1'b0;
		else
			d.ser_out = tx_serial_in;
		d.lb_rx = brk_on ? 1'b0 : tx_serial_in;

		// infrared output idles high unless infrared mode is on and loopback is off
		if (loop_on || !q.modem_control_reg[`URBS_MCR_IR])
			d.ir_out_n = 1'b1;
		else if (brk_on)
			d.ir_out_n = ir_pulse_n;
		else
			d.ir_out_n = ir_serial_in_n;
	end

	// burst enable comes from registered control, not the bus, to keep it glitch free
	assign ir_burst = q.modem_control_reg[`URBS_MCR_IR] & q.line_control_reg[`URBS_LCR_BRK] & ~q.modem_control_reg[`URBS_MCR_LOOP];

	urbs_ir_pulse u_ir_pulse (
		.clk     (clk),
		.rst_n   (rst_n),
		.en      (ir_burst),
		.pulse_n (ir_pulse_n)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q.bus      <= URBS_BUS_IDLE;
			q.dat      <= 32'h0000_0000;
			q.ack      <= 1'b0;
			q.modem_control_reg      <= `URBS_RST_MODEM_CTRL;
			q.line_control_reg      <= `URBS_RST_LINE_CTRL;
			q.fifo_control_reg      <= `URBS_RST_FIFO_CTRL;
			q.rts_n    <= 1'b1;
			q.ser_out  <= 1'b1;
			q.ir_out_n <= 1'b1;
			q.lb_rdy   <= 1'b0;
			q.lb_rx    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o         = q.dat;
	assign wb_ack_o         = q.ack;
	assign modem_ready_n    = q.rts_n;
	assign ser_out          = q.ser_out;
	assign ir_out_n         = q.ir_out_n;
	assign loop_modem_ready = q.lb_rdy;
	assign loop_rx_in       = q.lb_rx;

endmodule : urbs_ctrl

// ### dv/urbs_ctrl_sva.sv
// urbs_ctrl_sva: port checker for urbs_ctrl.
// assumes: bound onto urbs_ctrl, single clock, sync active-low reset.
`timescale 1ns/1ps
module urbs_ctrl_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        tx_serial_in,
	input wire logic        modem_ready_n,
	input wire logic        ser_out,
	input wire logic        ir_out_n,
	input wire logic        loop_modem_ready,
	input wire logic        loop_rx_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire req = wb_cyc_i && wb_stb_i;
	a_ack_one: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
	a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
	a_rdy_bit: assert property (!modem_ready_n |-> loop_modem_ready) else $error("rdy");
	// a high line after a low input bit can only mean loopback
	a_loop_hold: assert property ($past(rst_n) && ser_out && !$past(tx_serial_in)
		|-> modem_ready_n && ir_out_n) else $error("loop pins");
	a_brk_low: assert property ($past(rst_n) && !ser_out && $past(tx_serial_in)
		|-> !loop_rx_in) else $error("break rx");
	a_loop_rx: assert property ($past(rst_n) && !$past(tx_serial_in)
		|-> !loop_rx_in) else $error("rx path");
	c_req: cover property (req ##1 wb_ack_o);
	c_brk: cover property (!ser_out && $past(tx_serial_in));
	c_loop: cover property (ser_out && !loop_rx_in && $past(tx_serial_in));
endmodule : urbs_ctrl_sva
bind urbs_ctrl urbs_ctrl_sva u_sva (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.tx_serial_in, .modem_ready_n, .ser_out, .ir_out_n, .loop_modem_ready, .loop_rx_in);

// ### dv/urbs_modem.sv
// urbs_modem: behavioural modem watching the ready and serial lines.
// assumes: pins only; break length counted in clk cycles.
`timescale 1ns/1ps
module urbs_modem (
	input wire logic clk,
	input wire logic modem_ready_n,
	input wire logic sout,
	output logic     peer_ok,
	output int       low_cnt
);
	assign peer_ok = !modem_ready_n;
	always @(posedge clk) low_cnt <= sout ? 0 : low_cnt + 1;
endmodule : urbs_modem

// ### dv/test_urbs_ctrl.sv
// test_urbs_ctrl: directed bench for the mirror control block.
// assumes: auto flow built in; checker bound from its own file.
`timescale 1ns/1ps
`include "urbs_defines.svh"
module test_urbs_ctrl;
	localparam logic [31:0] MR = `URBS_ADR_MIRROR_RDY;
	localparam logic [31:0] MB = `URBS_ADR_MIRROR_BRK;
	localparam logic [31:0] MC = `URBS_ADR_MODEM_CTRL;
	localparam logic [31:0] LC = `URBS_ADR_LINE_CTRL;
	localparam logic [31:0] FC = `URBS_ADR_FIFO_CTRL;
	logic        clk, rst_n, cyc, stb, we, tx, ir_in, ack, rdy_n, sout, ir_n, lp_rdy, lp_rx, ok;
	logic [31:0] adr, wd, rdat, dat_o;
	logic [3:0]  sel;
	logic [4:0]  lvl;
	int          errors, n_checks, low_cnt;
	urbs_ctrl #(.AUTO_FLOW_OPTION(1'b1)) dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rx_fifo_level(lvl), .tx_serial_in(tx), .ir_serial_in_n(ir_in),
		.modem_ready_n(rdy_n), .ser_out(sout), .ir_out_n(ir_n), .loop_modem_ready(lp_rdy),
		.loop_rx_in(lp_rx));
	urbs_modem peer (.clk, .modem_ready_n(rdy_n), .sout, .peer_ok(ok), .low_cnt);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic settle;
		@(posedge clk);
		#1;
	endtask : settle
	// no count here: a missing ack is cut short by the watchdog
	task automatic wb(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic t_regs;
		logic [31:0] a [5];
		a = '{MR, MB, MC, LC, FC};
		foreach (a[i]) begin
			wb(1'b0, a[i], 32'h0);
			chk("reset", rdat, 32'h0);
		end
		wb(1'b1, MR, 32'hFFFE);
		wb(1'b0, MR, 32'h0);
		chk("mirror hi", rdat, 32'h0);
		wb(1'b1, 32'h5000_1000, 32'hFF);
		wb(1'b0, 32'h5000_1000, 32'h0);
		chk("unmapped", rdat, 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_rdy;
		wb(1'b1, MR, 32'hFFFF);
		settle;
		chk("rdy_n", 32'(rdy_n), 32'h0);
		chk("peer", 32'(ok), 32'h1);
		wb(1'b0, MC, 32'h0);
		chk("mcr", rdat, 32'h2);
		wb(1'b0, MR, 32'h0);
		chk("mirror", rdat, 32'h1);
		wb(1'b1, MC, 32'h0);
		wb(1'b0, MR, 32'h0);
		chk("alias", rdat, 32'h0);
		settle;
		chk("rdy off", 32'(rdy_n), 32'h1);
		$display("t_rdy done");
	endtask : t_rdy
	task automatic t_auto;
		logic [4:0] t [4];
		t = '{`URBS_TRIG_ONE, `URBS_TRIG_QUARTER, `URBS_TRIG_HALF, `URBS_TRIG_NEAR_FULL};
		wb(1'b1, MC, 32'h22);
		foreach (t[i]) begin
			wb(1'b1, FC, 32'(i * 64 + 1));
			lvl <= t[i] - 5'd1;
			settle;
			chk("below", 32'(rdy_n), 32'h0);
			@(posedge clk);
			lvl <= t[i];
			settle;
			chk("at trig", 32'(rdy_n), 32'h1);
		end
		wb(1'b1, FC, 32'hC0);
		settle;
		chk("fifo off", 32'(rdy_n), 32'h0);
		wb(1'b1, MC, 32'h0);
		$display("t_auto done");
	endtask : t_auto
	task automatic t_brk;
		@(posedge clk);
		tx <= 1'b1;
		wb(1'b1, MB, 32'h1);
		wb(1'b0, LC, 32'h0);
		chk("lcr", rdat, 32'h40);
		repeat (8) @(posedge clk);
		#1;
		chk("sout", 32'(sout), 32'h0);
		chk("held", 32'(low_cnt > 8), 32'h1);
		wb(1'b1, LC, 32'h0);
		wb(1'b0, MB, 32'h0);
		chk("mirror", rdat, 32'h0);
		settle;
		chk("release", 32'(sout), 32'h1);
		$display("t_brk done");
	endtask : t_brk
	task automatic t_ir;
		int lows;
		lows = 0;
		@(posedge clk);
		ir_in <= 1'b1;
		wb(1'b1, MC, 32'h40);
		wb(1'b1, MB, 32'h1);
		repeat (4) @(posedge clk);
		repeat (32) begin
			@(posedge clk);
			lows += int'(!ir_n);
		end
		chk("ir lows", 32'(lows), 32'd6);
		wb(1'b1, MB, 32'h0);
		wb(1'b1, MC, 32'h0);
		$display("t_ir done");
	endtask : t_ir
	task automatic t_loop;
		wb(1'b1, MC, 32'h12);
		wb(1'b1, MB, 32'h1);
		@(posedge clk);
		tx <= 1'b0;
		settle;
		chk("rdy_n", 32'(rdy_n), 32'h1);
		chk("lp rdy", 32'(lp_rdy), 32'h1);
		chk("sout", 32'(sout), 32'h1);
		@(posedge clk);
		tx <= 1'b1;
		settle;
		chk("lp rx", 32'(lp_rx), 32'h0);
		$display("t_loop done");
	endtask : t_loop
	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, tx, ir_in} = 5'h0;
		{adr, wd} = 64'h0;
		sel = 4'hF;
		lvl = 5'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_rdy;
		t_auto;
		t_brk;
		t_ir;
		t_loop;
		complete_run;
	end
	// about twenty times the expected run
	initial begin
		#20000;
		errors++;
		complete_run;
	end
endmodule : test_urbs_ctrl
